// file: rtl/lic_defs.svh
// Constants for the loop, interrupt and processor control execution unit
`ifndef LIC_DEFS_SVH
`define LIC_DEFS_SVH
// Opcode codes presented on instr_opcode
`define LIC_OP_LOOP      8'h01
`define LIC_OP_LOOP_WHILE_EQUAL     8'h02
`define LIC_OP_LOOP_WHILE_NOT_EQUAL    8'h03
`define LIC_OP_JUMP_IF_COUNT_ZERO      8'h04
`define LIC_OP_INT       8'h05
`define LIC_OP_INT3      8'h06
`define LIC_OP_INTO      8'h07
`define LIC_OP_INTERRUPT_RETURN      8'h08
`define LIC_OP_CLC       8'h09
`define LIC_OP_STC       8'h0a
`define LIC_OP_CMC       8'h0b
`define LIC_OP_CLD       8'h0c
`define LIC_OP_STD       8'h0d
`define LIC_OP_CLI       8'h0e
`define LIC_OP_STI       8'h0f
`define LIC_OP_HLT       8'h10
`define LIC_OP_WAIT      8'h11
`define LIC_OP_ESC       8'h12
`define LIC_OP_LOCK      8'h13
`define LIC_OP_NOP       8'h14
// Flag word bit positions
`define LIC_FB_CARRY     0
`define LIC_FB_ZERO      6
`define LIC_FB_STEP      8
`define LIC_FB_IE        9
`define LIC_FB_DIR       10
`define LIC_FB_OVF       11
// Interrupt types and reset values
`define LIC_TYPE_BREAK   8'h03
`define LIC_TYPE_OVF     8'h04
`define LIC_TYPE_NMI     8'h02
`define LIC_RST_CS       16'hffff
`define LIC_RST_IP       16'h0000
`define LIC_RST_FLAGS    16'h0000
`define LIC_RST_SP       16'h0000
`define LIC_RST_COUNT    16'h0000
`endif

// file: rtl/lic_pkg.sv
// Types for the loop, interrupt and processor control execution unit
package lic_pkg;
   typedef enum logic [3:0] {
      S_IDLE   = 4'b0000,
      S_PUSH_F = 4'b0001,
      S_PUSH_C = 4'b0010,
      S_PUSH_I = 4'b0011,
      S_VEC_I  = 4'b0100,
      S_VEC_C  = 4'b0101,
      S_POP_I  = 4'b0110,
      S_POP_C  = 4'b0111,
      S_POP_F  = 4'b1000,
      S_ESC_RD = 4'b1001,
      S_HALT   = 4'b1010,
      S_WAIT   = 4'b1011,
      S_INTA   = 4'b1100
   } lic_state_t;
endpackage : lic_pkg

// file: rtl/lic_exec.sv
// Execution unit for loop, interrupt and processor control instructions
// Summary of operation
// - Loop branches add a sign-extended byte displacement to the next address.
// - Plain loop decrements the count and branches when the result is nonzero.
// - Loop-while-equal branches when new count is nonzero and zero flag set.
// - Loop-while-not-equal branches when new count nonzero and zero flag clear.
// - Jump-if-count-zero branches when count is zero, count left alone.
// - Only maskable hardware requests run an acknowledge bus cycle.
// - Interrupt entry pushes flags, clears step and enable, pushes segment and pointer.
// - Vector sits at type times four: pointer first word, segment second.
// - One-byte breakpoint opcode acts as software interrupt type 3.
// - Overflow interrupt vectors through address 10 hex only with overflow set.
// - Interrupt return pops pointer, segment, then the whole flag word.
// - Carry may be cleared, set or inverted, other flags kept.
// - Direction flag set or cleared steers string index step direction.
// - With enable clear, maskable line ignored; nonmaskable and software still taken.
// - After enabling interrupts, maskable recognition waits one more instruction.
// - Halt stops until reset, nonmaskable, or enabled maskable request.
// - Wait stalls while the test input is inactive.
// - Escape shows its six-bit opcode, reads and drops a memory operand.
// - Lock prefix drives bus lock in maximum mode for the next instruction.
// - Halt, wait, escape, lock and no-op leave all flags unchanged.
// - Reset starts fetching from the top of memory where boot code lives.
`timescale 1ns/1ps
`include "lic_defs.svh"
module lic_exec (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Instruction handoff from the decoder
   input  wire logic        instr_valid,
   input  wire logic [7:0]  instr_opcode,
   input  wire logic [7:0]  instr_disp,
   input  wire logic [7:0]  instr_imm,
   input  wire logic        instr_mem_src,
   input  wire logic [19:0] instr_ea,
   input  wire logic [15:0] instr_next_ip,
   output logic             instr_ready,
   output logic             instr_done,
   // Register loads from the rest of the core
   input  wire logic        flags_wr,
   input  wire logic [15:0] flags_in,
   input  wire logic        count_wr,
   input  wire logic [15:0] count_in,
   input  wire logic        sp_wr,
   input  wire logic [15:0] sp_in,
   input  wire logic [15:0] stack_seg,
   // Architectural state out
   output logic [15:0]      flags,
   output logic [15:0]      loop_count,
   output logic [15:0]      instr_ptr,
   output logic [15:0]      code_seg,
   output logic [15:0]      stack_ptr,
   output logic             direction_flag,
   // System bus
   output logic             mem_req,
   output logic             mem_write,
   output logic [19:0]      mem_addr,
   output logic [15:0]      mem_wdata,
   output logic             inta_cycle,
   input  wire logic        mem_ack,
   input  wire logic [15:0] mem_rdata,
   // Pins
   input  wire logic        maskable_irq_line,
   input  wire logic        nmi_line,
   input  wire logic        test_n,
   input  wire logic        max_mode,
   output logic             bus_lock,
   output logic             halted,
   output logic             waiting,
   // Coprocessor escape
   output logic [5:0]       esc_opcode,
   output logic             esc_strobe
);
   lic_pkg::lic_state_t state_reg, state_next;
   logic [15:0] flags_reg, count_reg, ip_reg, cs_reg, sp_reg, ret_ip_reg;
   logic [7:0]  type_reg;
   logic        lock_pend_reg, irq_block_reg, nmi_pend_reg, nmi_old_reg;
   logic        req_reg, we_reg, inta_reg, lock_reg, ready_reg, done_reg, esc_stb_reg;
   logic [19:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [5:0]  esc_op_reg;
   logic [1:0]  irq_sync, nmi_sync, test_sync, mode_sync, park_reg;

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         irq_sync  <= 2'h0;
         nmi_sync  <= 2'h0;
         test_sync <= 2'h3;
         mode_sync <= 2'h0;
      end else begin
         irq_sync  <= {irq_sync[0], maskable_irq_line};
         nmi_sync  <= {nmi_sync[0], nmi_line};
         test_sync <= {test_sync[0], test_n};
         mode_sync <= {mode_sync[0], max_mode};
      end
   end

   // Decode of the presented instruction
   wire        in_idle     = (state_reg == lic_pkg::S_IDLE);
   wire        accept      = in_idle & ready_reg & instr_valid;
   wire        bus_go      = req_reg & mem_ack;
   wire        zero_flag   = flags_reg[`LIC_FB_ZERO];
   wire        overflow_flag = flags_reg[`LIC_FB_OVF];
   wire        carry_flag  = flags_reg[`LIC_FB_CARRY];
   wire        ie_flag     = flags_reg[`LIC_FB_IE];
   wire        op_loop     = (instr_opcode == `LIC_OP_LOOP);
   wire        loop_while_equal     = (instr_opcode == `LIC_OP_LOOP_WHILE_EQUAL);
   wire        loop_while_not_equal = (instr_opcode == `LIC_OP_LOOP_WHILE_NOT_EQUAL);
   wire        jump_if_count_zero   = (instr_opcode == `LIC_OP_JUMP_IF_COUNT_ZERO);
   wire        op_int      = (instr_opcode == `LIC_OP_INT);
   wire        op_int3     = (instr_opcode == `LIC_OP_INT3);
   wire        op_into     = (instr_opcode == `LIC_OP_INTO);
   wire        interrupt_return     = (instr_opcode == `LIC_OP_INTERRUPT_RETURN);
   wire        unmask_interrupts_op = (instr_opcode == `LIC_OP_STI);
   wire        halt_op     = (instr_opcode == `LIC_OP_HLT);
   wire        op_wait     = (instr_opcode == `LIC_OP_WAIT);
   wire        coprocessor_escape   = (instr_opcode == `LIC_OP_ESC);
   wire        op_lock     = (instr_opcode == `LIC_OP_LOCK);
   wire        is_loop     = op_loop | loop_while_equal | loop_while_not_equal;
   wire [15:0] count_dec   = count_reg - 16'h0001;
   wire        dec_nz      = (count_dec != 16'h0000);
   wire        take_branch = (op_loop & dec_nz)
                           | (loop_while_equal & dec_nz & zero_flag)
                           | (loop_while_not_equal & dec_nz & ~zero_flag)
                           | (jump_if_count_zero & (count_reg == 16'h0000));
   // Self-relative short target, reach limited to a signed byte
   wire [15:0] branch_ip   = instr_next_ip + {{8{instr_disp[7]}}, instr_disp};
   wire        soft_int    = op_int | op_int3 | (op_into & overflow_flag);
   wire [7:0]  soft_type   = op_int3 ? `LIC_TYPE_BREAK : (op_into ? `LIC_TYPE_OVF : instr_imm);
   // Enable flag and the one-instruction shadow gate the maskable line
   wire        maskable_irq_line_ok     = irq_sync[1] & ie_flag & ~irq_block_reg;
   wire        take_hw     = in_idle & ~accept & (nmi_pend_reg | maskable_irq_line_ok);
   wire        wake        = nmi_pend_reg | (irq_sync[1] & ie_flag);
   wire        last_xfer   = bus_go & ((state_reg == lic_pkg::S_VEC_C) | (state_reg == lic_pkg::S_POP_F)
                                      | (state_reg == lic_pkg::S_ESC_RD));
   wire        single_done = accept & ~soft_int & ~interrupt_return & ~halt_op
                           & ~(op_wait & test_sync[1]) & ~(coprocessor_escape & instr_mem_src);
   wire        done_now    = single_done | last_xfer
                           | ((state_reg == lic_pkg::S_WAIT) & ~test_sync[1])
                           | ((state_reg == lic_pkg::S_HALT) & wake);
   wire [19:0] stack_base  = {stack_seg, 4'h0};
   wire [19:0] push_addr   = stack_base + {4'h0, sp_reg - 16'h0002};
   wire [19:0] pop_addr    = stack_base + {4'h0, sp_reg};
   wire [19:0] vec_addr    = {10'h000, type_reg, 2'b00};
   wire        bus_state   = ~in_idle & (state_reg != lic_pkg::S_HALT) & (state_reg != lic_pkg::S_WAIT);

   // Next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         lic_pkg::S_IDLE: begin
            if (accept) begin
               if (soft_int) state_next = lic_pkg::S_PUSH_F;
               else if (interrupt_return) state_next = lic_pkg::S_POP_I;
               else if (halt_op) state_next = lic_pkg::S_HALT;
               else if (op_wait & test_sync[1]) state_next = lic_pkg::S_WAIT;
               else if (coprocessor_escape & instr_mem_src) state_next = lic_pkg::S_ESC_RD;
            end else if (nmi_pend_reg) state_next = lic_pkg::S_PUSH_F;
            else if (maskable_irq_line_ok) state_next = lic_pkg::S_INTA;
         end
         lic_pkg::S_INTA:   if (bus_go) state_next = lic_pkg::S_PUSH_F;
         lic_pkg::S_PUSH_F: if (bus_go) state_next = lic_pkg::S_PUSH_C;
         lic_pkg::S_PUSH_C: if (bus_go) state_next = lic_pkg::S_PUSH_I;
         lic_pkg::S_PUSH_I: if (bus_go) state_next = lic_pkg::S_VEC_I;
         lic_pkg::S_VEC_I:  if (bus_go) state_next = lic_pkg::S_VEC_C;
         lic_pkg::S_POP_I:  if (bus_go) state_next = lic_pkg::S_POP_C;
         lic_pkg::S_POP_C:  if (bus_go) state_next = lic_pkg::S_POP_F;
         lic_pkg::S_VEC_C, lic_pkg::S_POP_F, lic_pkg::S_ESC_RD: if (bus_go) state_next = lic_pkg::S_IDLE;
         lic_pkg::S_HALT:   if (wake) state_next = lic_pkg::S_IDLE;
         lic_pkg::S_WAIT:   if (~test_sync[1]) state_next = lic_pkg::S_IDLE;
         default:           state_next = lic_pkg::S_IDLE;
      endcase
   end

   // Sequencer and architectural registers
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_reg  <= lic_pkg::S_IDLE;
         flags_reg  <= `LIC_RST_FLAGS;
         count_reg  <= `LIC_RST_COUNT;
         ip_reg     <= `LIC_RST_IP;
         cs_reg     <= `LIC_RST_CS;
         sp_reg     <= `LIC_RST_SP;
         ret_ip_reg <= 16'h0000;
         type_reg   <= 8'h00;
      end else begin
         state_reg <= state_next;
         if (count_wr) count_reg <= count_in;
         else if (accept & is_loop) count_reg <= count_dec;
         if (sp_wr) sp_reg <= sp_in;
         else if (bus_go & ((state_reg == lic_pkg::S_PUSH_F) | (state_reg == lic_pkg::S_PUSH_C)
                            | (state_reg == lic_pkg::S_PUSH_I))) sp_reg <= sp_reg - 16'h0002;
         else if (bus_go & ((state_reg == lic_pkg::S_POP_I) | (state_reg == lic_pkg::S_POP_C)
                            | (state_reg == lic_pkg::S_POP_F))) sp_reg <= sp_reg + 16'h0002;
         if (accept & soft_int) begin
            type_reg   <= soft_type;
            ret_ip_reg <= instr_next_ip;
         end else if (take_hw) begin
            type_reg   <= `LIC_TYPE_NMI;
            ret_ip_reg <= ip_reg;
         end else if (bus_go & (state_reg == lic_pkg::S_INTA)) type_reg <= mem_rdata[7:0];
         // Instruction pointer: branch target, sequential, vector or stack
         if (accept & ~interrupt_return) ip_reg <= take_branch ? branch_ip : instr_next_ip;
         else if (bus_go & (state_reg == lic_pkg::S_VEC_I)) ip_reg <= mem_rdata;
         else if (bus_go & (state_reg == lic_pkg::S_POP_I)) ip_reg <= mem_rdata;
         if (bus_go & (state_reg == lic_pkg::S_VEC_C)) cs_reg <= mem_rdata;
         else if (bus_go & (state_reg == lic_pkg::S_POP_C)) cs_reg <= mem_rdata;
         // Flag updates; everything not named below keeps its value
         if (bus_go & (state_reg == lic_pkg::S_POP_F)) flags_reg <= mem_rdata;
         else if (bus_go & (state_reg == lic_pkg::S_PUSH_F)) begin
            flags_reg[`LIC_FB_STEP] <= 1'b0;
            flags_reg[`LIC_FB_IE]   <= 1'b0;
         end else if (accept) begin
            case (instr_opcode)
               `LIC_OP_CLC: flags_reg[`LIC_FB_CARRY] <= 1'b0;
               `LIC_OP_STC: flags_reg[`LIC_FB_CARRY] <= 1'b1;
               `LIC_OP_CMC: flags_reg[`LIC_FB_CARRY] <= ~carry_flag;
               `LIC_OP_CLD: flags_reg[`LIC_FB_DIR]   <= 1'b0;
               `LIC_OP_STD: flags_reg[`LIC_FB_DIR]   <= 1'b1;
               `LIC_OP_CLI: flags_reg[`LIC_FB_IE]    <= 1'b0;
               `LIC_OP_STI: flags_reg[`LIC_FB_IE]    <= 1'b1;
               default:     flags_reg <= flags_reg;
            endcase
         end else if (flags_wr) flags_reg <= flags_in;
      end
   end

   // Interrupt shadow, nonmaskable latch, lock prefix tracking
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         irq_block_reg <= 1'b0;
         nmi_pend_reg  <= 1'b0;
         nmi_old_reg   <= 1'b0;
         lock_pend_reg <= 1'b0;
         lock_reg      <= 1'b0;
      end else begin
         nmi_old_reg <= nmi_sync[1];
         // A new edge wins over the clear of the same cycle
         if (nmi_sync[1] & ~nmi_old_reg) nmi_pend_reg <= 1'b1;
         else if (take_hw & nmi_pend_reg) nmi_pend_reg <= 1'b0;
         if (accept & unmask_interrupts_op) irq_block_reg <= 1'b1;
         else if (done_now) irq_block_reg <= 1'b0;
         if (accept & op_lock) lock_pend_reg <= 1'b1;
         else if (accept) lock_pend_reg <= 1'b0;
         if (accept & lock_pend_reg & ~op_lock) lock_reg <= mode_sync[1];
         else if (done_reg) lock_reg <= 1'b0;                                     // Drop after the done pulse
      end
   end

   // Bus cycle driver; a request stands until acknowledged, then drops for a cycle
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         req_reg   <= 1'b0;
         we_reg    <= 1'b0;
         inta_reg  <= 1'b0;
         addr_reg  <= 20'h00000;
         wdata_reg <= 16'h0000;
      end else begin
         req_reg  <= bus_state & ~bus_go & (state_next == state_reg);
         inta_reg <= (state_reg == lic_pkg::S_INTA) & ~bus_go;
         we_reg   <= (state_reg == lic_pkg::S_PUSH_F) | (state_reg == lic_pkg::S_PUSH_C)
                   | (state_reg == lic_pkg::S_PUSH_I);
         case (state_reg)
            lic_pkg::S_PUSH_F: begin addr_reg <= push_addr; wdata_reg <= flags_reg; end
            lic_pkg::S_PUSH_C: begin addr_reg <= push_addr; wdata_reg <= cs_reg; end
            lic_pkg::S_PUSH_I: begin addr_reg <= push_addr; wdata_reg <= ret_ip_reg; end
            lic_pkg::S_VEC_I:  addr_reg <= vec_addr;
            lic_pkg::S_VEC_C:  addr_reg <= vec_addr + 20'h00002;
            lic_pkg::S_ESC_RD: addr_reg <= instr_ea;
            lic_pkg::S_POP_I, lic_pkg::S_POP_C, lic_pkg::S_POP_F: addr_reg <= pop_addr;
            default:           addr_reg <= addr_reg;
         endcase
      end
   end

   // Handshake and status outputs
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ready_reg   <= 1'b0;
         done_reg    <= 1'b0;
         esc_stb_reg <= 1'b0;
         esc_op_reg  <= 6'h00;
         park_reg    <= 2'h0;
      end else begin
         ready_reg   <= (state_next == lic_pkg::S_IDLE) & ~take_hw & ~accept;
         done_reg    <= done_now;
         esc_stb_reg <= accept & coprocessor_escape;
         if (accept & coprocessor_escape) esc_op_reg <= instr_imm[5:0];
         park_reg    <= {state_next == lic_pkg::S_WAIT, state_next == lic_pkg::S_HALT};
      end
   end
   assign instr_ready    = ready_reg;
   assign instr_done     = done_reg;
   assign flags          = flags_reg;
   assign loop_count     = count_reg;
   assign instr_ptr      = ip_reg;
   assign code_seg       = cs_reg;
   assign stack_ptr      = sp_reg;
   assign direction_flag = flags_reg[`LIC_FB_DIR];
   assign mem_req        = req_reg;
   assign mem_write      = we_reg;
   assign mem_addr       = addr_reg;
   assign mem_wdata      = wdata_reg;
   assign inta_cycle     = inta_reg;
   assign bus_lock       = lock_reg;
   assign halted         = park_reg[0];
   assign waiting        = park_reg[1];
   assign esc_opcode     = esc_op_reg;
   assign esc_strobe     = esc_stb_reg;
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   a_loop_decrement: assert property (accept & op_loop & ~count_wr |=> count_reg == $past(count_reg) - 16'h0001)
      else $error("loop count not decremented");
   a_loop_exit: assert property (accept & op_loop & (count_reg == 16'h0001) |=> ip_reg == $past(instr_next_ip))
      else $error("loop branched at zero");
   a_jump_if_count_zero_keep: assert property (accept & jump_if_count_zero & ~count_wr |=> $stable(count_reg))
      else $error("count changed by jump-if-zero");
   a_carry_invert: assert property (accept & (instr_opcode == `LIC_OP_CMC) & ~flags_wr
      |=> flags_reg == ($past(flags_reg) ^ 16'h0001))
      else $error("carry invert wrong");
   a_entry_clears: assert property ((state_reg == lic_pkg::S_PUSH_F) & bus_go |=> ~flags_reg[`LIC_FB_IE]
      & ~flags_reg[`LIC_FB_STEP]) else $error("entry left flags set");
   a_vector_addr: assert property (req_reg & (state_reg == lic_pkg::S_VEC_I) |-> addr_reg == {10'h000, type_reg, 2'b00})
      else $error("vector address wrong");
   a_inta_only_hw: assert property (inta_reg |-> state_reg == lic_pkg::S_INTA)
      else $error("acknowledge outside hardware entry");
   a_masked_ignore: assert property (in_idle & ~ie_flag & ~nmi_pend_reg |=> state_reg != lic_pkg::S_INTA)
      else $error("masked request taken");
   a_halt_holds: assert property ((state_reg == lic_pkg::S_HALT) & ~wake |=> state_reg == lic_pkg::S_HALT)
      else $error("halt left without cause");
   a_wait_holds: assert property ((state_reg == lic_pkg::S_WAIT) & test_sync[1] |=> state_reg == lic_pkg::S_WAIT)
      else $error("wait released early");
   c_loop_taken: cover property (accept & op_loop & take_branch);
   c_soft_entry: cover property ((state_reg == lic_pkg::S_VEC_C) & bus_go);
   c_interrupt_return_done: cover property ((state_reg == lic_pkg::S_POP_F) & bus_go);
   c_halt_wake: cover property ((state_reg == lic_pkg::S_HALT) ##1 in_idle);
endmodule : lic_exec

// file: verification/lic_mem_model.sv
// Memory and interrupt acknowledge side model of the system bus
`timescale 1ns/1ps
module lic_mem_model #(parameter int LAT = 1, parameter logic [15:0] ACK_TYPE = 16'h0020) (
   // Clock
   input  wire logic        core_clk,
   // System bus
   input  wire logic        mem_req,
   input  wire logic        mem_write,
   input  wire logic [19:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   input  wire logic        inta_cycle,
   output logic             mem_ack,
   output logic [15:0]      mem_rdata
);
   logic [15:0] mem [int];
   logic [19:0] last_rd;
   int          cnt = 0;
   initial mem_ack = 1'b0;
   initial mem_rdata = 16'h0000;
   // Answer after LAT waits; idle data toggles so a late sample never looks valid
   always @(posedge core_clk) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && cnt < LAT) cnt <= cnt + 1;
      else if (mem_req && !mem_ack) begin
         cnt     <= 0;
         mem_ack <= 1'b1;
         if (mem_write) mem[mem_addr] = mem_wdata;
         else if (inta_cycle) mem_rdata <= ACK_TYPE;
         else mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000;
         if (!mem_write) last_rd <= mem_addr;
      end
   end
endmodule : lic_mem_model

// file: verification/tb.sv
// Self-checking bench for the loop, interrupt and control unit
`timescale 1ns/1ps
`include "lic_defs.svh"
module tb;
   logic [15:0] flags_in, count_in, sp_in, stack_seg, instr_next_ip, flags, loop_count, instr_ptr, code_seg;
   logic [15:0] stack_ptr, mem_wdata, mem_rdata;
   logic [19:0] instr_ea, mem_addr;
   logic [7:0]  instr_opcode, instr_disp, instr_imm;
   logic [5:0]  esc_opcode;
   logic core_clk, reset, instr_valid, instr_mem_src, instr_ready, instr_done, flags_wr, count_wr, sp_wr;
   logic direction_flag, mem_req, mem_write, inta_cycle, mem_ack, maskable_irq_line, nmi_line, test_n;
   logic max_mode, bus_lock, halted, waiting, esc_strobe, inta_seen, lock_seen, esc_seen;
   int   error_cnt, tests_run, cyc, i;
   logic [7:0]  fop [6] = '{`LIC_OP_STC, `LIC_OP_CMC, `LIC_OP_CMC, `LIC_OP_CLC, `LIC_OP_STD, `LIC_OP_CLD};
   logic [15:0] fexp [6] = '{16'h0841, 16'h0840, 16'h0841, 16'h0840, 16'h0c40, 16'h0840};
   lic_exec i_lic_exec (.core_clk, .reset, .instr_valid, .instr_opcode, .instr_disp, .instr_imm, .instr_mem_src,
      .instr_ea, .instr_next_ip, .instr_ready, .instr_done, .flags_wr, .flags_in, .count_wr, .count_in, .sp_wr,
      .sp_in, .stack_seg, .flags, .loop_count, .instr_ptr, .code_seg, .stack_ptr, .direction_flag, .mem_req,
      .mem_write, .mem_addr, .mem_wdata, .inta_cycle, .mem_ack, .mem_rdata, .maskable_irq_line, .nmi_line,
      .test_n, .max_mode, .bus_lock, .halted, .waiting, .esc_opcode, .esc_strobe);
   lic_mem_model #(.LAT(2)) i_lic_mem_model (.core_clk, .mem_req, .mem_write, .mem_addr, .mem_wdata,
      .inta_cycle, .mem_ack, .mem_rdata);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Sticky monitors and the hang limit
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      inta_seen <= inta_seen | inta_cycle;
      lock_seen <= lock_seen | bus_lock;
      esc_seen <= esc_seen | esc_strobe;
      if (cyc == 6000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic ld(input logic [15:0] f, input logic [15:0] c, input logic [15:0] s);
      @(negedge core_clk);
      {flags_wr, count_wr, sp_wr, flags_in, count_in, sp_in} = {3'h7, f, c, s};
      @(negedge core_clk);
      {flags_wr, count_wr, sp_wr} = 3'h0;
   endtask : ld
   task automatic wd();
      for (int n = 0; n < 300 && instr_done !== 1'b1; n++) @(negedge core_clk);
      chk(instr_done, 1'b1);
      @(negedge core_clk);
   endtask : wd
   // Offer one instruction once ready; next address is always 0100
   task automatic ex(input logic [7:0] op, input logic [7:0] d, input logic [7:0] im, input bit w);
      for (int n = 0; n < 50 && instr_ready !== 1'b1; n++) @(negedge core_clk);
      chk(instr_ready, 1'b1);
      {instr_opcode, instr_disp, instr_imm, instr_next_ip, instr_valid} = {op, d, im, 16'h0100, 1'b1};
      @(negedge core_clk);
      instr_valid = 1'b0;
      if (w) wd();
   endtask : ex
   task automatic t_loop();
      ld(16'h0040, 16'h0002, 16'h0100);
      ex(`LIC_OP_LOOP, 8'h80, 8'h00, 1); chk(instr_ptr, 16'h0080); chk(loop_count, 16'h0001);
      ex(`LIC_OP_LOOP, 8'h80, 8'h00, 1); chk(instr_ptr, 16'h0100); chk(loop_count, 16'h0000);
      ld(16'h0040, 16'h0002, 16'h0100);
      ex(`LIC_OP_LOOP_WHILE_EQUAL, 8'h7f, 8'h00, 1); chk(instr_ptr, 16'h017f); chk(flags, 16'h0040);
      ex(`LIC_OP_LOOP_WHILE_NOT_EQUAL, 8'hfe, 8'h00, 1); chk(instr_ptr, 16'h0100);
      ld(16'h0000, 16'h0003, 16'h0100);
      ex(`LIC_OP_LOOP_WHILE_NOT_EQUAL, 8'hfe, 8'h00, 1); chk(instr_ptr, 16'h00fe);
      ex(`LIC_OP_LOOP_WHILE_EQUAL, 8'h7f, 8'h00, 1); chk(instr_ptr, 16'h0100);
      ld(16'h0000, 16'h0000, 16'h0100);
      ex(`LIC_OP_JUMP_IF_COUNT_ZERO, 8'h7f, 8'h00, 1); chk(instr_ptr, 16'h017f); chk(loop_count, 16'h0000);
   endtask : t_loop
   task automatic t_flag();
      ld(16'h0840, 16'h0001, 16'h0100);
      foreach (fop[k]) begin
         ex(fop[k], 8'h00, 8'h00, 1); chk(flags, fexp[k]); chk(direction_flag, fexp[k][10]);
      end
      lock_seen = 1'b0;
      ex(`LIC_OP_LOCK, 8'h00, 8'h00, 1); ex(`LIC_OP_NOP, 8'h00, 8'h00, 1); chk(lock_seen, 1'b1);
      {max_mode, lock_seen} = 2'b00;
      ex(`LIC_OP_LOCK, 8'h00, 8'h00, 1); ex(`LIC_OP_NOP, 8'h00, 8'h00, 1); chk(lock_seen, 1'b0);
      ex(`LIC_OP_JUMP_IF_COUNT_ZERO, 8'h7f, 8'h00, 1); chk(instr_ptr, 16'h0100); chk(flags, 16'h0840);
   endtask : t_flag
   task automatic t_int();
      for (i = 8; i < 20'h88; i += 2) i_lic_mem_model.mem[i] = 16'(i * 257);
      ld(16'h0341, 16'h0000, 16'h0100);
      inta_seen = 1'b0;
      ex(`LIC_OP_INT, 8'h00, 8'h21, 1); chk(instr_ptr, 16'h8484); chk(code_seg, 16'h8686);
      chk(stack_ptr, 16'h00fa); chk(flags, 16'h0041); chk(i_lic_mem_model.mem[20'hfe], 16'h0341);
      chk(i_lic_mem_model.mem[20'hfc], 16'hffff); chk(i_lic_mem_model.mem[20'hfa], 16'h0100);
      ex(`LIC_OP_INTERRUPT_RETURN, 8'h00, 8'h00, 1); chk(instr_ptr, 16'h0100); chk(code_seg, 16'hffff);
      chk(flags, 16'h0341); chk(stack_ptr, 16'h0100);
      ex(`LIC_OP_INT3, 8'h00, 8'h00, 1); chk(instr_ptr, 16'h0c0c); chk(code_seg, 16'h0e0e);
      ld(16'h0000, 16'h0000, 16'h0100);
      ex(`LIC_OP_INTO, 8'h00, 8'h00, 1); chk(instr_ptr, 16'h0100); chk(stack_ptr, 16'h0100);
      ld(16'h0800, 16'h0000, 16'h0100);
      ex(`LIC_OP_INTO, 8'h00, 8'h00, 1); chk(instr_ptr, 16'h1010); chk(code_seg, 16'h1212);
      chk(inta_seen, 1'b0);
   endtask : t_int
   task automatic t_sync();
      ld(16'h0000, 16'h0000, 16'h0100);
      maskable_irq_line = 1'b1;
      ex(`LIC_OP_HLT, 8'h00, 8'h00, 0); repeat (6) @(negedge core_clk); chk(halted, 1'b1);
      nmi_line = 1'b1;
      wd(); wd(); chk(instr_ptr, 16'h0808); chk(inta_seen, 1'b0); chk(halted, 1'b0);
      {nmi_line, maskable_irq_line, test_n} = 3'b001;
      ex(`LIC_OP_WAIT, 8'h00, 8'h00, 0); repeat (6) @(negedge core_clk); chk(waiting, 1'b1);
      test_n = 1'b0;
      wd(); chk(waiting, 1'b0);
      ld(16'h0841, 16'h0000, 16'h0100);
      {instr_mem_src, instr_ea, esc_seen} = {1'b1, 20'h00200, 1'b0};
      ex(`LIC_OP_ESC, 8'h00, 8'hea, 1); chk(esc_opcode, 6'h2a); chk(i_lic_mem_model.last_rd, 20'h00200);
      chk(flags, 16'h0841);
      chk(esc_seen, 1'b1); {instr_mem_src, instr_ea} = {1'b0, 20'h00300};
      ex(`LIC_OP_ESC, 8'h00, 8'h15, 1); chk(esc_opcode, 6'h15); chk(i_lic_mem_model.last_rd, 20'h00200);
   endtask : t_sync
   // Maskable entry: held off by the enable shadow, then acknowledged
   task automatic t_irq();
      ld(16'h0000, 16'h0000, 16'h0100);
      {inta_seen, maskable_irq_line} = 2'b01;
      ex(`LIC_OP_STI, 8'h00, 8'h00, 1); repeat (6) @(negedge core_clk); chk(inta_seen, 1'b0);
      ex(`LIC_OP_NOP, 8'h00, 8'h00, 1); wd(); chk(instr_ptr, 16'h8080); chk(inta_seen, 1'b1);
      chk(code_seg, 16'h8282); chk(flags, 16'h0000); chk(i_lic_mem_model.mem[20'hfe], 16'h0200);
      chk(i_lic_mem_model.mem[20'hfa], 16'h0100);
      maskable_irq_line = 1'b0;
   endtask : t_irq
   task automatic report_and_stop();
      $display("errors=%0d checks=%0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   initial begin
      {error_cnt, tests_run, cyc, inta_seen, lock_seen, reset, test_n, max_mode} = {96'h0, 5'h1f};
      {instr_valid, instr_mem_src, flags_wr, count_wr, sp_wr, maskable_irq_line, nmi_line} = 7'h00;
      {instr_opcode, instr_disp, instr_imm, instr_ea, instr_next_ip, flags_in, count_in, sp_in, stack_seg} = '0;
      repeat (3) @(negedge core_clk);
      chk(code_seg, 16'hffff); chk(instr_ptr, 16'h0000);
      reset = 1'b0;
      t_loop();
      t_flag();
      t_int();
      t_sync();
      t_irq();
      report_and_stop();
   end
endmodule : tb
